// File: hw/txdw_pkg.sv
// package: constants and types for the transmit descriptor walker
package txdw_pkg;

	// ----------------------------------------------------------------
	// descriptor layout
	// ----------------------------------------------------------------
	localparam int          DESC_WORDS     = 4;
	localparam logic [31:0] OFS_WORD3      = 32'h0000000C;
	localparam logic [31:0] WORD_STEP      = 32'h00000004;
	localparam int          OFS_FIELD_LSB  = 16;
	localparam int          FLG_FIRST      = 31;
	localparam int          FLG_LAST       = 30;
	localparam int          FLG_HELD       = 29;
	localparam int          FLG_QEND       = 28;
	localparam int          FLG_ABORT      = 27;
	localparam int          FLG_CRC        = 26;
	localparam logic [31:0] NULL_LINK      = 32'h00000000;

	// ----------------------------------------------------------------
	// register map (byte offsets) and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_HEAD       = 8'h04;
	localparam logic [7:0]  REG_STATUS     = 8'h08;
	localparam logic [7:0]  REG_CUR        = 8'h0C;
	localparam int          CTRL_START     = 0;
	localparam int          CTRL_TEARDOWN  = 1;
	localparam int          STAT_BUSY      = 0;
	localparam int          STAT_HALTED    = 1;
	localparam int          STAT_ABORTED   = 2;
	localparam int          STAT_TD_PEND   = 3;
	localparam logic [31:0] HEAD_RST       = 32'h00000000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_DECIDE, S_DATA, S_RELINK,
		S_WB_SOP, S_WB_END, S_ABORT, S_HALT
	} walk_state_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
		logic        last;
		logic        crc_append;
		logic [15:0] pkt_len;
	} tx_byte_t;

endpackage

// File: hw/word_byte_cache.sv
// one-word cache that serves single bytes from any byte address
`timescale 1ns/1ps
`default_nettype none
module word_byte_cache (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        flush_in,
	input  wire logic        load_in,
	input  wire logic [31:0] load_addr_in,
	input  wire logic [31:0] load_data_in,
	input  wire logic [31:0] byte_addr_in,
	output logic             hit_out,
	output logic [7:0]       byte_out
);
	logic [31:0] word_r;
	logic [29:0] tag_r;
	logic        valid_r;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_r  <= 32'h00000000;
			tag_r   <= 30'h00000000;
			valid_r <= 1'b0;
		end else if (load_in) begin
			word_r  <= load_data_in;
			tag_r   <= load_addr_in[31:2];
			valid_r <= 1'b1;
		end else if (flush_in) begin
			valid_r <= 1'b0;
		end
	end

	// little-endian lane pick; any byte alignment is served
	assign hit_out  = valid_r && (tag_r == byte_addr_in[31:2]);
	assign byte_out = word_r[{byte_addr_in[1:0], 3'b000} +: 8];
endmodule // word_byte_cache
`default_nettype wire

// File: hw/tx_buffer_descriptor_walker.sv
// transmit buffer descriptor walker with wishbone control registers
// Operation
// RULE1: descriptors are four aligned 32-bit words, all four fetched
// RULE2: word0 link, word1 buffer address, word2 offset high, length low
// RULE3: word3 low half packet length, upper bits the six flags
// RULE4: link is next descriptor word address; zero ends the queue
// RULE5: never write link, buffer address, offset or lengths back
// RULE6: follow a link patched before it is read; halt if read null
// RULE7: software patches only null links and restarts on queue end
// RULE8: buffer address may be any byte, data taken from that byte
// RULE9: skip offset leading bytes before valid data
// RULE10: offset applies only on the first fragment descriptor
// RULE11: software keeps offset below the buffer length
// RULE12: buffer length is exactly the valid byte count of a fragment
// RULE13: packet length is read only from the first fragment
// RULE14: software makes fragment lengths sum to the packet length
// RULE15: software completes every field before queueing
// RULE16: after the last fragment clear the held flag in first descriptor
// RULE17: last fragment with null link gets its queue end flag set
// RULE18: crc flag clear means append generated crc, set means supplied
// RULE19: teardown marks abort done on first unsent packet and stops
// RULE20: reserved flag bits ignored on read and kept on write
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_descriptor_walker
	import txdw_pkg::*;
#(
	parameter int WB_AW = 8
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [WB_AW-1:0] wb_adr_in,
	input  wire logic [31:0] wb_dat_in,
	input  wire logic [3:0]  wb_sel_in,
	output logic [31:0]      wb_dat_out,
	output logic             wb_ack_out,
	output mem_req_t         mem_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	output tx_byte_t         tx_out,
	input  wire logic        tx_ready_in
);
	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (WB_AW < 4 || WB_AW > 8) begin : g_bad_aw
		$error("WB_AW must lie between 4 and 8");
	end

	walk_state_t state_r;
	logic [31:0] desc_r [DESC_WORDS];
	logic [31:0] desc_addr_r;
	logic [1:0]  idx_r;
	logic [31:0] sop_addr_r;
	logic [31:0] sop_w3_r;
	logic [31:0] link_r;
	logic [31:0] byte_addr_r;
	logic [15:0] left_r;
	logic        halted_r;
	logic        aborted_r;
	logic [31:0] head_r;
	logic        td_pend_r;
	logic        ack_r;
	logic [31:0] rdat_r;
	logic        start_pulse;
	logic        td_done;
	logic        wr_hit;
	logic        cache_hit;
	logic [7:0]  cache_byte;
	logic        byte_take;
	logic        word_fill;
	logic [31:0] w3;
	logic [15:0] buf_len;
	logic [7:0]  adr8;

	assign w3      = desc_r[3];
	assign buf_len = desc_r[2][15:0];                             // [RULE2]
	assign adr8    = 8'(wb_adr_in);

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	assign wr_hit      = wb_cyc_in && wb_stb_in && wb_we_in && !ack_r;
	assign start_pulse = wr_hit && adr8 == REG_CTRL && wb_sel_in[0]
		&& wb_dat_in[CTRL_START];
	assign wb_ack_out  = ack_r;
	assign wb_dat_out  = rdat_r;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_in && wb_stb_in && !ack_r;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			head_r <= HEAD_RST;
		end else if (wr_hit && adr8 == REG_HEAD) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_in[b]) begin
					head_r[8*b +: 8] <= wb_dat_in[8*b +: 8];
				end
			end
		end
	end

	// set wins over the completion clear
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			td_pend_r <= 1'b0;
		end else if (wr_hit && adr8 == REG_CTRL && wb_sel_in[0]
			&& wb_dat_in[CTRL_TEARDOWN]) begin
			td_pend_r <= 1'b1;
		end else if (td_done) begin
			td_pend_r <= 1'b0;
		end
	end

	// unmapped offsets read zero and still acknowledge
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdat_r <= 32'h00000000;
		end else begin
			case (adr8)
				REG_HEAD:   rdat_r <= head_r;
				REG_CUR:    rdat_r <= desc_addr_r;
				REG_STATUS: rdat_r <= {28'h0000000, td_pend_r, aborted_r,
					halted_r, state_r != S_IDLE && state_r != S_HALT};
				default:    rdat_r <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// memory master and byte stream
	// ----------------------------------------------------------------
	always_comb begin
		mem_out = '0;
		case (state_r)
			S_FETCH: begin
				mem_out.req  = 1'b1;
				mem_out.addr = desc_addr_r + {28'h0000000, idx_r, 2'b00};
			end
			S_DATA: begin
				mem_out.req  = !cache_hit;
				mem_out.addr = {byte_addr_r[31:2], 2'b00};          // [RULE8]
			end
			S_RELINK: begin
				mem_out.req  = 1'b1;
				mem_out.addr = desc_addr_r;                          // [RULE6]
			end
			S_WB_SOP: begin
				mem_out.req   = 1'b1;
				mem_out.we    = 1'b1;
				mem_out.addr  = sop_addr_r + OFS_WORD3;              // [RULE5]
				mem_out.wdata = sop_w3_r;                            // [RULE20]
				mem_out.wdata[FLG_HELD] = 1'b0;                      // [RULE16]
				mem_out.wdata[FLG_QEND] = sop_w3_r[FLG_QEND] ||
					(sop_addr_r == desc_addr_r && link_r == NULL_LINK);
			end
			S_WB_END: begin
				mem_out.req   = 1'b1;
				mem_out.we    = 1'b1;
				mem_out.addr  = desc_addr_r + OFS_WORD3;
				mem_out.wdata = w3 | (32'h1 << FLG_QEND);           // [RULE17]
			end
			S_ABORT: begin
				mem_out.req   = 1'b1;
				mem_out.we    = 1'b1;
				mem_out.addr  = desc_addr_r + OFS_WORD3;
				mem_out.wdata = w3 | (32'h1 << FLG_ABORT);          // [RULE19]
			end
			default: mem_out = '0;
		endcase
	end

	assign word_fill = state_r == S_DATA && !cache_hit && mem_ack_in;
	assign byte_take = state_r == S_DATA && cache_hit && tx_ready_in;
	assign td_done   = state_r == S_ABORT && mem_ack_in
		|| td_pend_r && (state_r == S_IDLE || state_r == S_HALT);

	always_comb begin
		tx_out            = '0;
		tx_out.valid      = state_r == S_DATA && cache_hit;
		tx_out.data       = cache_byte;
		tx_out.last       = w3[FLG_LAST] && left_r == 16'h0001;
		tx_out.crc_append = !sop_w3_r[FLG_CRC];                  // [RULE18]
		tx_out.pkt_len    = sop_w3_r[15:0];                      // [RULE13]
	end

	word_byte_cache u_cache (
		.sys_clk_in   (sys_clk_in),
		.rst_n_in     (rst_n_in),
		.flush_in     (state_r == S_DECIDE),
		.load_in      (word_fill),
		.load_addr_in (byte_addr_r),
		.load_data_in (mem_rdata_in),
		.byte_addr_in (byte_addr_r),
		.hit_out      (cache_hit),
		.byte_out     (cache_byte)
	);

	// ----------------------------------------------------------------
	// descriptor walk
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r     <= S_IDLE;
			desc_addr_r <= 32'h00000000;
			idx_r       <= 2'h0;
			sop_addr_r  <= 32'h00000000;
			sop_w3_r    <= 32'h00000000;
			link_r      <= 32'h00000000;
			byte_addr_r <= 32'h00000000;
			left_r      <= 16'h0000;
			halted_r    <= 1'b0;
			aborted_r   <= 1'b0;
			for (int i = 0; i < DESC_WORDS; i++) begin
				desc_r[i] <= 32'h00000000;
			end
		end else begin
			case (state_r)
				S_IDLE, S_HALT: begin
					// a null head leaves the channel parked
					if (start_pulse && head_r != NULL_LINK) begin
						desc_addr_r <= {head_r[31:2], 2'b00};          // [RULE1]
						idx_r       <= 2'h0;
						halted_r    <= 1'b0;
						aborted_r   <= 1'b0;
						state_r     <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (mem_ack_in) begin
						desc_r[idx_r] <= mem_rdata_in;                  // [RULE1]
						idx_r         <= idx_r + 2'h1;
						if (idx_r == 2'h3) begin
							state_r <= S_DECIDE;
						end
					end
				end
				S_DECIDE: begin
					// only the top three flags steer the walk
					if (w3[FLG_FIRST]) begin                          // [RULE3]
						if (td_pend_r) begin
							state_r <= S_ABORT;
						end else if (!w3[FLG_HELD]) begin
							halted_r <= 1'b1;
							state_r  <= S_HALT;
						end else begin
							sop_addr_r  <= desc_addr_r;
							sop_w3_r    <= w3;                            // [RULE13]
							byte_addr_r <= desc_r[1] +
								{16'h0000, desc_r[2][31:OFS_FIELD_LSB]};    // [RULE9]
							left_r  <= buf_len;                           // [RULE12]
							state_r <= buf_len == 16'h0000 ? S_RELINK : S_DATA;
						end
					end else begin
						byte_addr_r <= desc_r[1];                       // [RULE10]
						left_r      <= buf_len;
						state_r <= buf_len == 16'h0000 ? S_RELINK : S_DATA;
					end
				end
				S_DATA: begin
					if (byte_take) begin
						byte_addr_r <= byte_addr_r + WORD_STEP[31:0] - 32'h3;
						left_r      <= left_r - 16'h0001;
						if (left_r == 16'h0001) begin
							state_r <= S_RELINK;
						end
					end
				end
				S_RELINK: begin
					// fresh read catches a link patched during the fragment
					if (mem_ack_in) begin
						link_r <= mem_rdata_in;                           // [RULE6]
						if (w3[FLG_LAST]) begin
							state_r <= S_WB_SOP;
						end else if (mem_rdata_in == NULL_LINK) begin
							halted_r <= 1'b1;                               // [RULE4]
							state_r  <= S_HALT;
						end else begin
							desc_addr_r <= {mem_rdata_in[31:2], 2'b00};     // [RULE4]
							idx_r       <= 2'h0;
							state_r     <= S_FETCH;
						end
					end
				end
				S_WB_SOP: begin
					if (mem_ack_in) begin
						if (link_r != NULL_LINK) begin
							desc_addr_r <= {link_r[31:2], 2'b00};
							idx_r       <= 2'h0;
							state_r     <= S_FETCH;
						end else if (sop_addr_r != desc_addr_r) begin
							state_r <= S_WB_END;
						end else begin
							halted_r <= 1'b1;
							state_r  <= S_HALT;
						end
					end
				end
				S_WB_END: begin
					if (mem_ack_in) begin
						halted_r <= 1'b1;                                 // [RULE17]
						state_r  <= S_HALT;
					end
				end
				S_ABORT: begin
					// nothing after the aborted packet is touched
					if (mem_ack_in) begin
						aborted_r <= 1'b1;                                // [RULE19]
						halted_r  <= 1'b1;
						state_r   <= S_HALT;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	desc_fetch_align_a: assert property ( // [RULE1]
		state_r == S_FETCH |-> mem_out.addr[1:0] == 2'b00 && !mem_out.we)
		else $error("descriptor fetch not word aligned");
	only_word3_write_a: assert property ( // [RULE5]
		mem_out.req && mem_out.we |-> mem_out.addr == desc_addr_r + OFS_WORD3
		|| mem_out.addr == sop_addr_r + OFS_WORD3)
		else $error("write outside the flag word");
	reserved_kept_a: assert property ( // [RULE20]
		(state_r == S_WB_END |-> mem_out.wdata[25:0] == w3[25:0]) and
		(state_r == S_WB_SOP |-> mem_out.wdata[25:0] == sop_w3_r[25:0]))
		else $error("reserved or length bits altered");
	offset_applied_a: assert property ( // [RULE9]
		state_r == S_DECIDE && w3[FLG_FIRST] && w3[FLG_HELD] && !td_pend_r
		|=> byte_addr_r == $past(desc_r[1]) + $past(desc_r[2][31:16]))
		else $error("offset not added on first fragment");
	offset_ignored_a: assert property ( // [RULE10]
		state_r == S_DECIDE && !w3[FLG_FIRST]
		|=> byte_addr_r == $past(desc_r[1]) && left_r == $past(buf_len))
		else $error("offset used on later fragment");
	link_followed_a: assert property ( // [RULE6]
		state_r == S_RELINK && mem_ack_in && !w3[FLG_LAST]
		&& mem_rdata_in != 32'h0
		|=> state_r == S_FETCH && desc_addr_r[31:2] == $past(mem_rdata_in[31:2]))
		else $error("patched link not followed");
	held_cleared_a: assert property ( // [RULE16]
		state_r == S_WB_SOP |-> !mem_out.wdata[FLG_HELD]
		&& mem_out.addr == sop_addr_r + OFS_WORD3)
		else $error("held flag not returned");
	queue_end_a: assert property ( // [RULE17]
		state_r == S_WB_END |-> mem_out.wdata[FLG_QEND] and
		(mem_ack_in |=> state_r == S_HALT && halted_r))
		else $error("queue end not marked");
	abort_mark_a: assert property ( // [RULE19]
		state_r == S_ABORT && mem_ack_in
		|-> mem_out.wdata[FLG_ABORT] ##1 state_r == S_HALT ##1 !td_pend_r)
		else $error("teardown not completed");
	crc_mode_a: assert property ( // [RULE18]
		tx_out.valid |-> tx_out.crc_append == !sop_w3_r[FLG_CRC])
		else $error("crc mode mismatch");

	single_pkt_c: cover property (state_r == S_WB_SOP && mem_ack_in
		&& link_r == 32'h0);
	multi_frag_c: cover property (state_r == S_RELINK && mem_ack_in
		&& !w3[FLG_LAST] && mem_rdata_in != 32'h0);
	teardown_c:   cover property (state_r == S_ABORT && mem_ack_in);
	queue_end_c:  cover property (state_r == S_WB_END && mem_ack_in);
endmodule // tx_buffer_descriptor_walker
`default_nettype wire

// File: dv/host_mem_model.sv
// host memory model answering the walker's word requests
`timescale 1ns/1ps
`default_nettype none
module host_mem_model
	import txdw_pkg::*;
(
	input  wire logic     sys_clk_in,
	input  wire logic     rst_n_in,
	input  wire logic     slow_in,
	input  wire mem_req_t mem_in,
	output logic          mem_ack_out,
	output logic [31:0]   mem_rdata_out
);
	logic [31:0] mem [256];
	logic [31:0] rdata_r;
	logic [1:0]  wait_r;

	// ----------------------------------------------------------------
	// storage and answer timing
	// ----------------------------------------------------------------
	// byte pattern everywhere, descriptors are laid over it by the bench
	initial begin
		for (int i = 0; i < 256; i++)
			for (int k = 0; k < 4; k++)
				mem[i][8*k+:8] = 8'(4*i+k) ^ 8'hA5;
	end

	// answer after 1 or 4 cycles; word index ignores the byte lanes
	always @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mem_ack_out <= 1'b0;
			wait_r      <= 2'h0;
			rdata_r     <= 32'h0;
		end else begin
			mem_ack_out <= 1'b0;
			if (mem_in.req && !mem_ack_out) begin
				if (wait_r == (slow_in ? 2'h3 : 2'h0)) begin
					wait_r      <= 2'h0;
					mem_ack_out <= 1'b1;
					rdata_r     <= mem[mem_in.addr[9:2]];
					if (mem_in.we)
						mem[mem_in.addr[9:2]] <= mem_in.wdata;
				end else begin
					wait_r <= wait_r + 2'h1;
				end
			end
		end
	end

	// outside an answer the bus carries no stale word
	assign mem_rdata_out = mem_ack_out ? rdata_r : ~rdata_r;
endmodule // host_mem_model
`default_nettype wire

// File: dv/tx_buffer_descriptor_walker_tb_top.sv
// testbench for the transmit descriptor walker
`timescale 1ns/1ps
`default_nettype none
module tx_buffer_descriptor_walker_tb_top
	import txdw_pkg::*;
;
	localparam logic [31:0] HELD = 32'h1 << FLG_HELD;
	localparam logic [31:0] QEND = 32'h1 << FLG_QEND;
	logic        sys_clk_in, rst_n_in, wb_cyc, wb_stb, wb_we, wb_ack;
	logic        tx_ready, mem_ack, slow;
	logic [7:0]  wb_adr;
	logic [31:0] wb_dat, wb_rd, mem_rdata, rd;
	logic [15:0] cycles, plen;
	mem_req_t    mem_req;
	tx_byte_t    tx;
	logic [9:0]  bq [$];
	logic [7:0]  eq [$];
	int          failures = 0;
	int          tests_run = 0;

	tx_buffer_descriptor_walker i_tx_buffer_descriptor_walker (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
		.wb_dat_in(wb_dat), .wb_sel_in(4'hF), .wb_dat_out(wb_rd),
		.wb_ack_out(wb_ack), .mem_out(mem_req), .mem_ack_in(mem_ack),
		.mem_rdata_in(mem_rdata), .tx_out(tx), .tx_ready_in(tx_ready));
	host_mem_model i_host_mem_model (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .slow_in(slow),
		.mem_in(mem_req), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata));

	// ----------------------------------------------------------------
	// clock, byte sink with stalls, timeout
	// ----------------------------------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in) begin
		cycles   <= cycles + 16'h1;
		tx_ready <= cycles[1:0] != 2'h3;
		if (tx.valid && tx_ready) begin
			bq.push_back({tx.last, tx.crc_append, tx.data});
			plen = tx.pkt_len;
		end
		if (cycles == 16'd20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge sys_clk_in);
		end while (wb_ack !== 1'b1);
		rd = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task put(input int a, input logic [31:0] w0, w1, w2, w3);
		i_host_mem_model.mem[a/4]   = w0;
		i_host_mem_model.mem[a/4+1] = w1;
		i_host_mem_model.mem[a/4+2] = w2;
		i_host_mem_model.mem[a/4+3] = w3;
	endtask

	task expect_buf(input int a, input int n);
		for (int i = 0; i < n; i++)
			eq.push_back(8'(a+i) ^ 8'hA5);
	endtask

	task wait_bytes(input int k);
		int n;
		n = 0;
		while (bq.size() < k && n < 4000) begin
			@(posedge sys_clk_in);
			n++;
		end
	endtask

	task go(input logic [31:0] head);
		wb(1'b1, REG_HEAD, head);
		wb(1'b1, REG_CTRL, 32'h1);
	endtask

	task finish(input logic crc, input logic [15:0] pl);
		int n;
		n = 0;
		wait_bytes(eq.size());
		do begin
			wb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[STAT_BUSY] !== 1'b0 && n < 50);
		check(32'(rd[STAT_BUSY]), 32'h0); // walk ended
		check(32'(bq.size()), 32'(eq.size())); // byte count
		for (int i = 0; i < eq.size() && i < bq.size(); i++) begin
			check(32'(bq[i][7:0]), 32'(eq[i])); // data bytes
			check(32'(bq[i][9]), 32'(i == eq.size()-1)); // final marker
			check(32'(bq[i][8]), 32'(!crc)); // crc append
		end
		check(32'(plen), 32'(pl)); // first length only
		bq.delete();
		eq.delete();
	endtask

	task report_and_stop;
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n_in = 1'b0;
		{wb_cyc, wb_stb, wb_we, tx_ready, slow} = 5'h0;
		wb_adr = 8'h00;
		wb_dat = 32'h0;
		cycles = 16'h0;
		repeat (5) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		wb(1'b0, REG_HEAD, 32'h0);
		check(rd, HEAD_RST);
		wb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, REG_HEAD, 32'h44);
		wb(1'b0, REG_HEAD, 32'h0);
		check(rd, 32'h44);
		// one fragment, odd buffer byte, offset, reserved bit set
		put(32'h40, NULL_LINK, 32'h103, 32'h00030005, 32'hE0100005);
		expect_buf(32'h106, 5);
		go(32'h40);
		finish(1'b0, 16'h5);
		check(i_host_mem_model.mem[16], NULL_LINK); // kept
		check(i_host_mem_model.mem[17], 32'h103); // kept
		check(i_host_mem_model.mem[18], 32'h00030005); // kept
		check(i_host_mem_model.mem[19], 32'hE0100005 & ~HELD | QEND);
		wb(1'b0, REG_STATUS, 32'h0);
		check(32'(rd[STAT_HALTED]), 32'h1); // stops on null link
		wb(1'b0, REG_CUR, 32'h0);
		check(rd, 32'h40); // parked on the final descriptor
		// two fragments, slow memory, link patched while streaming
		slow <= 1'b1;
		put(32'h50, NULL_LINK, 32'h120, 32'h00020003, 32'hA4100007);
		put(32'h60, NULL_LINK, 32'h141, 32'h00050004, 32'h40000063);
		expect_buf(32'h122, 3);
		expect_buf(32'h141, 4);
		go(32'h50);
		wait_bytes(1);
		i_host_mem_model.mem[20] = 32'h60; // null link patched
		finish(1'b1, 16'h7);
		check(i_host_mem_model.mem[23], 32'hA4100007 & ~HELD);
		check(i_host_mem_model.mem[27], 32'h40000063 | QEND);
		// teardown while the first of two packets streams
		put(32'h70, 32'h80, 32'h160, 32'h00000002, 32'hE0000002);
		put(32'h80, NULL_LINK, 32'h170, 32'h00000002, 32'hE0000002);
		expect_buf(32'h160, 2);
		go(32'h70);
		wait_bytes(1);
		wb(1'b1, REG_CTRL, 32'h2);
		finish(1'b0, 16'h2);
		check(i_host_mem_model.mem[31], 32'hC0000002);
		check(i_host_mem_model.mem[35], 32'hE8000002); // abort mark
		wb(1'b0, REG_STATUS, 32'h0);
		check(32'(rd[STAT_ABORTED]), 32'h1);
		check(32'(rd[STAT_TD_PEND]), 32'h0); // teardown done
		// held flag clear: parked with no data and no write-back
		put(32'h90, NULL_LINK, 32'h180, 32'h00000002, 32'hC0000002);
		go(32'h90);
		repeat (40) @(posedge sys_clk_in);
		wb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h2); // halted, not busy
		check(32'(bq.size()), 32'h0); // no bytes sent
		check(i_host_mem_model.mem[39], 32'hC0000002); // untouched
		// teardown while parked completes at once
		wb(1'b1, REG_CTRL, 32'h2);
		wb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h2); // pending cleared
		report_and_stop();
	end
endmodule // tx_buffer_descriptor_walker_tb_top
`default_nettype wire
